// ==== core/ssp_host.sv ====
`timescale 1ns/1ps
`include "ssp_cfg.svh"
`default_nettype none

module ssp_host #(
  parameter int unsigned WAKE_CYC = `SSP_WAKE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  ssp_link_if.host link
);

  // ----------------------------------------------------------------------
  // data line synchroniser
  // ----------------------------------------------------------------------
  logic sdio_s;

  ssp_sync #(.INIT(1'b1)) u_sdio_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(link.sdio),
    .q(sdio_s)
  );

  ssp_pkg::ssp_host_s r_reg;
  ssp_pkg::ssp_host_s r_next;
  logic setup;
  logic wr_acc;
  logic tick;
  logic is_read;
  logic mapped;

  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pwrite & r_reg.pready;
  assign tick = (r_reg.tmr == 24'h0);
  assign is_read = ~r_reg.cmd[`SSP_CTRL_DIR_BIT];
  assign mapped = (paddr == `SSP_A_CTRL) || (paddr == `SSP_A_STAT) || (paddr == `SSP_A_RDATA);

  // ----------------------------------------------------------------------
  // apb slave and serial sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    // every access completes in its first access cycle
    r_next.pready = setup;
    r_next.pslverr = setup & ~mapped;
    if (setup && !pwrite) begin
      case (paddr)
        `SSP_A_CTRL: r_next.prdata = {16'h0000, r_reg.cmd};
        `SSP_A_STAT: r_next.prdata = {29'h0, r_reg.pd, r_reg.done, r_reg.st != ssp_pkg::H_IDLE};
        `SSP_A_RDATA: r_next.prdata = {24'h000000, r_reg.rdata};
        default: r_next.prdata = 32'h0;
      endcase
    end
    if (wr_acc && paddr == `SSP_A_STAT && pwdata[`SSP_ST_DONE_BIT]) begin
      r_next.done = 1'b0;
    end
    if (r_reg.st != ssp_pkg::H_IDLE && !tick) begin
      r_next.tmr = r_reg.tmr - 24'h1;
    end

    case (r_reg.st)
      ssp_pkg::H_IDLE: begin
        // only this controller starts a command; a busy write is dropped
        if (wr_acc && paddr == `SSP_A_CTRL) begin
          r_next.cmd = pwdata[15:0];
          r_next.shift = {pwdata[15:0]};
          r_next.nbit = 4'h0;
          r_next.sclk = 1'b0;
          r_next.oe = 1'b1;
          r_next.dout = pwdata[15];
          r_next.tmr = 24'(`SSP_HALF_CYC - 1);
          r_next.st = ssp_pkg::H_LOW;
        end
      end
      ssp_pkg::H_LOW: begin
        if (tick) begin
          r_next.sclk = 1'b1;
          r_next.tmr = 24'(`SSP_HALF_CYC - 1);
          r_next.st = ssp_pkg::H_HIGH;
          if (is_read && r_reg.nbit[3]) begin
            r_next.rdata = {r_reg.rdata[6:0], sdio_s};
          end
        end
      end
      ssp_pkg::H_HIGH: begin
        if (tick) begin
          if (r_reg.nbit == 4'hf) begin
            r_next.oe = 1'b0;
            r_next.st = ssp_pkg::H_GAP;
            if (is_read) begin
              r_next.tmr = 24'(`SSP_RDGAP_CYC - 1);
            end else if (r_reg.cmd[14:8] == `SSP_CFG_ADDR && r_reg.cmd[`SSP_PD_BIT]) begin
              r_next.pd = 1'b1;
              r_next.tmr = 24'((`SSP_TURN_CYC > `SSP_PD_SETTLE_CYC ?
                `SSP_TURN_CYC : `SSP_PD_SETTLE_CYC) - 1);
            end else if (r_reg.cmd[14:8] == `SSP_CFG_ADDR && r_reg.pd) begin
              r_next.pd = 1'b0;
              r_next.tmr = 24'(WAKE_CYC - 1);
            end else begin
              r_next.tmr = 24'(`SSP_TURN_CYC - 1);
            end
          end else if (is_read && r_reg.nbit == 4'h7) begin
            // let go before the device turns the line around
            r_next.oe = 1'b0;
            r_next.tmr = 24'(`SSP_TURN_CYC - 1);
            r_next.st = ssp_pkg::H_TURN;
          end else begin
            r_next.nbit = r_reg.nbit + 4'h1;
            r_next.sclk = 1'b0;
            r_next.shift = {r_reg.shift[14:0], 1'b0};
            r_next.dout = r_reg.shift[14];
            r_next.tmr = 24'(`SSP_HALF_CYC - 1);
            r_next.st = ssp_pkg::H_LOW;
          end
        end
      end
      ssp_pkg::H_TURN: begin
        if (tick) begin
          r_next.nbit = 4'h8;
          r_next.sclk = 1'b0;
          r_next.tmr = 24'(`SSP_HALF_CYC - 1);
          r_next.st = ssp_pkg::H_LOW;
        end
      end
      ssp_pkg::H_GAP: begin
        // a started command always runs to its sixteenth bit first
        if (tick) begin
          r_next.done = 1'b1;
          r_next.st = ssp_pkg::H_IDLE;
        end
      end
      default: r_next.st = ssp_pkg::H_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg.st <= ssp_pkg::H_IDLE;
      r_reg.sclk <= 1'b1;
      r_reg.oe <= 1'b0;
      r_reg.dout <= 1'b1;
      r_reg.shift <= 16'h0000;
      r_reg.nbit <= 4'h0;
      r_reg.tmr <= 24'h0;
      r_reg.rdata <= 8'h00;
      r_reg.cmd <= 16'h0000;
      r_reg.done <= 1'b0;
      r_reg.pd <= 1'b0;
      r_reg.pready <= 1'b0;
      r_reg.pslverr <= 1'b0;
      r_reg.prdata <= 32'h0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign prdata = r_reg.prdata;
  assign pready = r_reg.pready;
  assign pslverr = r_reg.pslverr;
  assign link.sclk = r_reg.sclk;
  assign link.host_sdio_out = r_reg.dout;
  assign link.host_sdio_oe = r_reg.oe;

endmodule // ssp_host

`default_nettype wire

// ==== core/ssp_cfg.svh ====
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH

// ----------------------------------------------------------------------
// serial link register map (seven-bit addresses)
// ----------------------------------------------------------------------
`define SSP_CFG_ADDR 7'h40
`define SSP_STAT_ADDR 7'h41
`define SSP_PD_BIT 6
`define SSP_CFG_RST 8'h00
// arbitrary identification value carried in status bits 7:1
`define SSP_STAT_ID 7'h15

// ----------------------------------------------------------------------
// controller registers on the apb side (byte addresses)
// ----------------------------------------------------------------------
`define SSP_A_CTRL 8'h00
`define SSP_A_STAT 8'h04
`define SSP_A_RDATA 8'h08
`define SSP_CTRL_DIR_BIT 15
`define SSP_ST_BUSY_BIT 0
`define SSP_ST_DONE_BIT 1
`define SSP_ST_PD_BIT 2

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define SSP_CLK_PERIOD_NS 32'h28
// 100 us: read turnaround and recovery after a write
`define SSP_T_TURN_US 32'h64
`define SSP_TURN_CYC ((`SSP_T_TURN_US * 32'h3e8 + `SSP_CLK_PERIOD_NS - 32'h1) / `SSP_CLK_PERIOD_NS)
// 250 ns after a read
`define SSP_T_RDGAP_NS 32'hfa
`define SSP_RDGAP_CYC ((`SSP_T_RDGAP_NS + `SSP_CLK_PERIOD_NS - 32'h1) / `SSP_CLK_PERIOD_NS)
// 32 device clocks after entering power-down
`define SSP_PD_SETTLE_CYC 32'h20
// 50 ms after leaving power-down
`define SSP_T_WAKE_MS 32'h32
`define SSP_WAKE_CYC ((`SSP_T_WAKE_MS * 32'hf4240 + `SSP_CLK_PERIOD_NS - 32'h1) / `SSP_CLK_PERIOD_NS)
// 90 ms transaction timeout, longest time so rounded down
`define SSP_T_TMO_MS 32'h5a
`define SSP_TMO_CYC ((`SSP_T_TMO_MS * 32'hf4240) / `SSP_CLK_PERIOD_NS)
// 160 ns release limit after the last data bit
`define SSP_T_REL_NS 32'ha0
`define SSP_REL_CYC (`SSP_T_REL_NS / `SSP_CLK_PERIOD_NS)
// half period of the serial clock made by the controller
`define SSP_HALF_CYC 32'ha
// idle light pulse: on for this many of every 256 cycles
`define SSP_LED_ON_CYC 8'h10

`endif

// ==== core/ssp_pkg.sv ====
`default_nettype none

package ssp_pkg;

  typedef enum logic [1:0] {DEV_IDLE, DEV_RX, DEV_TX, DEV_HOLD} ssp_dev_e;

  typedef struct packed {
    ssp_dev_e ph;
    logic sclk_prev;
    logic [4:0] cnt;
    logic [7:0] hdr;
    logic [7:0] shift;
    logic oe;
    logic dout;
    logic [21:0] tmo;
    logic [7:0] cfg;
    logic [7:0] led_cnt;
    logic led_out;
    logic led_oe;
  } ssp_dev_s;

  typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_TURN, H_GAP} ssp_host_e;

  typedef struct packed {
    ssp_host_e st;
    logic sclk;
    logic oe;
    logic dout;
    logic [15:0] shift;
    logic [3:0] nbit;
    logic [23:0] tmr;
    logic [7:0] rdata;
    logic [15:0] cmd;
    logic done;
    logic pd;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ssp_host_s;

  typedef struct packed {
    logic s1;
    logic s2;
  } ssp_sync_s;

endpackage // ssp_pkg

`default_nettype wire

// ==== core/ssp_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface ssp_link_if;
  logic sclk;
  logic host_sdio_out;
  logic host_sdio_oe;
  logic dev_sdio_out;
  logic dev_sdio_oe;
  logic sdio;

  // pull-up when nobody drives; both driving is a fault, device wins here
  assign sdio = dev_sdio_oe ? dev_sdio_out : (host_sdio_oe ? host_sdio_out : 1'b1);

  modport sensor(input sclk, input sdio, output dev_sdio_out, output dev_sdio_oe);
  modport host(output sclk, output host_sdio_out, output host_sdio_oe, input sdio);
endinterface // ssp_link_if

`default_nettype wire

// ==== core/ssp_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module ssp_sync #(
  parameter logic INIT = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic d,
  output logic q
);
  ssp_pkg::ssp_sync_s r_reg;
  ssp_pkg::ssp_sync_s r_next;

  always_comb begin
    r_next.s1 = d;
    r_next.s2 = r_reg.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= {INIT, INIT};
    end else begin
      r_reg <= r_next;
    end
  end

  assign q = r_reg.s2;
endmodule // ssp_sync

`default_nettype wire

// ==== core/ssp_sensor.sv ====
// Behaviour
// - bit 6 write enters, clearing leaves power-down
// - host waits 32 clocks after power-down write
// - no timeout in power-down; host sends whole commands
// - power-down writes change only bit 6
// - host waits 50 ms after leaving power-down
// - settings survive power-down unchanged
// - configuration register sits at address 1000000
// - power-down tri-states light drive and data line
// - light steady on motion, pulsed when idle
// - host starts transfers and makes the clock
// - write: direction 1, address, then data byte
// - change on falling, sample on rising edges
// - read: direction 0, address, device sends data
// - host releases data after last address bit
// - host holds clock 100 us before read data
// - last data bit held until next falling edge
// - drive after last address bit, release within 160 ns
// - unmapped write ignored, unmapped read gives zero
// - power-down write leaves data line released
// - host waits 100 us after a write
// - host waits 250 ns after a read
// - transaction timeout resets the serial port
`timescale 1ns/1ps
`include "ssp_cfg.svh"
`default_nettype none

module ssp_sensor #(
  parameter int unsigned TIMEOUT_CYC = `SSP_TMO_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  ssp_link_if.sensor link,
  input wire logic motion_detected,
  output logic light_drive_out,
  output logic light_drive_oe,
  output logic power_down_bit,
  output logic [7:0] cfg_value
);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic sclk_s;
  logic sdio_s;

  // clock idles high, so a reset value of one avoids a false first edge
  ssp_sync #(.INIT(1'b1)) u_sclk_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(link.sclk),
    .q(sclk_s)
  );

  ssp_sync #(.INIT(1'b1)) u_sdio_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(link.sdio),
    .q(sdio_s)
  );

  // ----------------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------------
  function automatic logic [7:0] read_value(input logic [6:0] addr, input logic [7:0] cfg);
    logic [7:0] v;
    v = 8'h00;
    case (addr)
      `SSP_CFG_ADDR: v = cfg;
      `SSP_STAT_ADDR: v = {`SSP_STAT_ID, ~cfg[`SSP_PD_BIT]};
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  ssp_pkg::ssp_dev_s r_reg;
  ssp_pkg::ssp_dev_s r_next;
  logic rise;
  logic fall;
  logic pd_now;
  logic [7:0] byte_in;

  assign rise = sclk_s & ~r_reg.sclk_prev;
  assign fall = ~sclk_s & r_reg.sclk_prev;
  assign pd_now = r_reg.cfg[`SSP_PD_BIT];

  always_comb begin
    r_next = r_reg;
    r_next.sclk_prev = sclk_s;
    r_next.led_cnt = r_reg.led_cnt + 8'h01;
    byte_in = {r_reg.shift[6:0], sdio_s};

    // transaction timer runs only while a command is in flight
    if ((r_reg.ph == ssp_pkg::DEV_RX || r_reg.ph == ssp_pkg::DEV_TX) && !pd_now) begin
      r_next.tmo = r_reg.tmo + 22'h1;
    end

    // falling edges: the device changes its data line here
    if (fall) begin
      case (r_reg.ph)
        ssp_pkg::DEV_IDLE: begin
          r_next.ph = ssp_pkg::DEV_RX;
          r_next.tmo = 22'h0;
        end
        ssp_pkg::DEV_TX: begin
          r_next.oe = 1'b1;
          r_next.dout = r_reg.shift[7];
          r_next.shift = {r_reg.shift[6:0], 1'b0};
        end
        ssp_pkg::DEV_HOLD: begin
          // this falling edge already opens the next command
          r_next.oe = 1'b0;
          r_next.ph = ssp_pkg::DEV_RX;
          r_next.cnt = 5'h00;
          r_next.tmo = 22'h0;
        end
        default: begin
        end
      endcase
    end

    // rising edges: the device samples the data line here
    if (rise) begin
      if (r_reg.ph == ssp_pkg::DEV_IDLE || r_reg.ph == ssp_pkg::DEV_HOLD) begin
        r_next.ph = ssp_pkg::DEV_RX;
        r_next.tmo = 22'h0;
        r_next.oe = 1'b0;
      end
      r_next.cnt = r_reg.cnt + 5'h01;
      if (r_reg.ph != ssp_pkg::DEV_TX) begin
        r_next.shift = byte_in;
      end
      if (r_reg.ph != ssp_pkg::DEV_TX && r_reg.cnt == 5'h07) begin
        r_next.hdr = byte_in;
        if (!byte_in[7]) begin
          r_next.shift = read_value(byte_in[6:0], r_reg.cfg);
          r_next.ph = ssp_pkg::DEV_TX;
        end
      end
      if (r_reg.cnt == 5'h0f) begin
        r_next.cnt = 5'h00;
        if (r_reg.ph == ssp_pkg::DEV_TX) begin
          r_next.ph = ssp_pkg::DEV_HOLD;
        end else begin
          r_next.ph = ssp_pkg::DEV_IDLE;
          // write commit: direction bit one, then address, then data
          if (r_reg.hdr[7] && r_reg.hdr[6:0] == `SSP_CFG_ADDR) begin
            if (pd_now) begin
              r_next.cfg[`SSP_PD_BIT] = byte_in[`SSP_PD_BIT];
            end else begin
              r_next.cfg = byte_in;
            end
          end
          // any other address leaves the registers untouched
          r_next.oe = 1'b0;
        end
      end
    end

    // a stalled command is thrown away once the timer expires
    if (r_reg.tmo == 22'(TIMEOUT_CYC - 1) && !pd_now) begin
      r_next.ph = ssp_pkg::DEV_IDLE;
      r_next.cnt = 5'h00;
      r_next.tmo = 22'h0;
      r_next.oe = 1'b0;
    end

    // power-down floats both pins; settings are never cleared by it
    r_next.oe = r_next.oe & ~r_next.cfg[`SSP_PD_BIT];
    r_next.led_oe = ~r_next.cfg[`SSP_PD_BIT];
    r_next.led_out = ~r_next.cfg[`SSP_PD_BIT] &
      (motion_detected | (r_reg.led_cnt < `SSP_LED_ON_CYC));
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg.ph <= ssp_pkg::DEV_IDLE;
      r_reg.sclk_prev <= 1'b1;
      r_reg.cnt <= 5'h00;
      r_reg.hdr <= 8'h00;
      r_reg.shift <= 8'h00;
      r_reg.oe <= 1'b0;
      r_reg.dout <= 1'b0;
      r_reg.tmo <= 22'h0;
      r_reg.cfg <= `SSP_CFG_RST;
      r_reg.led_cnt <= 8'h00;
      r_reg.led_out <= 1'b0;
      r_reg.led_oe <= 1'b0;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // the device only ever answers; it has no way to start a transfer
  assign link.dev_sdio_out = r_reg.dout;
  assign link.dev_sdio_oe = r_reg.oe;
  assign light_drive_out = r_reg.led_out;
  assign light_drive_oe = r_reg.led_oe;
  assign power_down_bit = r_reg.cfg[`SSP_PD_BIT];
  assign cfg_value = r_reg.cfg;

endmodule // ssp_sensor

`default_nettype wire

// ==== testbench/ssp_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none

module ssp_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sclk,
  input wire logic host_sdio_out,
  input wire logic host_sdio_oe,
  input wire logic dev_sdio_out,
  input wire logic dev_sdio_oe,
  input wire logic sdio,
  input wire logic motion_detected,
  input wire logic light_drive_out,
  input wire logic light_drive_oe,
  input wire logic power_down_bit
);
  // ----------------------------------------------------------------
  // serial clock edge tracking
  // ----------------------------------------------------------------
  logic sclk_q;
  logic rd;
  logic [4:0] rises;
  logic [11:0] hi_cnt;
  logic [3:0] since_fall;
  logic rise;
  logic fall;
  assign rise = sclk & ~sclk_q;
  assign fall = sclk_q & ~sclk;

  // hi_cnt and since_fall saturate so a long idle high clock never wraps into a short one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_q <= 1'b1;
      rd <= 1'b0;
      rises <= 5'h0;
      hi_cnt <= 12'h0;
      since_fall <= 4'hf;
    end else begin
      sclk_q <= sclk;
      hi_cnt <= !sclk ? 12'h0 : (hi_cnt == 12'hfff ? hi_cnt : hi_cnt + 12'h1);
      since_fall <= fall ? 4'h0 : (since_fall == 4'hf ? since_fall : since_fall + 4'h1);
      if (rise) begin
        rises <= rises + 5'h1;
      end else if (fall && rises == 5'h10) begin
        rises <= 5'h0;
      end
      if (rise && rises == 5'h0) begin
        rd <= ~sdio;
      end
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_pd_pins_quiet: assert property (power_down_bit && $past(power_down_bit) |->
    !dev_sdio_oe && !light_drive_oe) else $error("pins driven in power-down");
  chk_drive_only_read: assert property (dev_sdio_oe |-> rd &&
    (rises >= 5'h8 || rises == 5'h0)) else $error("device drives outside a read");
  chk_release_fast: assert property (fall && rises == 5'h10 && rd |-> ##[0:4] !dev_sdio_oe)
    else $error("device late releasing data line");
  chk_hold_last_bit: assert property (rises == 5'h10 && rd && dev_sdio_oe && sclk |=>
    dev_sdio_oe && $stable(dev_sdio_out)) else $error("last data bit not held");
  chk_dev_change_fall: assert property (dev_sdio_oe && $past(dev_sdio_oe) &&
    $changed(dev_sdio_out) |-> since_fall <= 4'h4) else $error("device data moved off falling");
  chk_host_change_fall: assert property (host_sdio_oe && $changed(host_sdio_out) |->
    !sclk && $past(sclk)) else $error("host data moved off falling");
  chk_host_release: assert property (rd && rises == 5'h8 && !sclk |-> !host_sdio_oe)
    else $error("host still drives after address");
  chk_read_turnaround: assert property (fall && rd && rises == 5'h8 |-> hi_cnt >= 12'h9c4)
    else $error("read turnaround too short");
  chk_read_gap: assert property (fall && rd && rises == 5'h10 |-> hi_cnt >= 12'h7)
    else $error("gap after read too short");
  chk_write_recovery: assert property (fall && !rd && rises == 5'h10 |-> hi_cnt >= 12'h9c4)
    else $error("gap after write too short");
  chk_light_steady: assert property (motion_detected && $past(motion_detected) &&
    $past(motion_detected, 2) && light_drive_oe |-> light_drive_out) else $error("light not steady");

  cover property (fall && rd && rises == 5'h10 && dev_sdio_oe);
  cover property ($rose(power_down_bit));
  cover property ($fell(power_down_bit));
  cover property (!motion_detected && $rose(light_drive_out));
endmodule // ssp_assertions

`default_nettype wire

// ==== testbench/sensor_serial_port_power_down_test.sv ====
`timescale 1ns/1ps
`include "ssp_cfg.svh"
`default_nettype none

module sensor_serial_port_power_down_test;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic last_err;
  logic motion_detected;
  logic light_drive_out;
  logic light_drive_oe;
  logic power_down_bit;
  logic [7:0] cfg_value;
  logic sclk_q = 1'b1;
  logic [15:0] mon_sh = 16'h0;
  int failures = 0;
  int compares = 0;
  int cycles = 0;

  ssp_link_if ssp_link_if_i ();
  // timeout kept well above a read with its turnaround
  ssp_sensor #(.TIMEOUT_CYC(20000)) ssp_sensor_i (.pclk(pclk), .presetn(presetn),
    .link(ssp_link_if_i), .motion_detected(motion_detected), .light_drive_out(light_drive_out),
    .light_drive_oe(light_drive_oe), .power_down_bit(power_down_bit), .cfg_value(cfg_value));
  // wake wait above the write recovery so both gaps are seen
  ssp_host #(.WAKE_CYC(2600)) ssp_host_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(ssp_link_if_i));
  ssp_assertions ssp_assertions_i (.pclk(pclk), .presetn(presetn), .sclk(ssp_link_if_i.sclk),
    .host_sdio_out(ssp_link_if_i.host_sdio_out), .host_sdio_oe(ssp_link_if_i.host_sdio_oe),
    .dev_sdio_out(ssp_link_if_i.dev_sdio_out), .dev_sdio_oe(ssp_link_if_i.dev_sdio_oe),
    .sdio(ssp_link_if_i.sdio), .motion_detected(motion_detected),
    .light_drive_out(light_drive_out), .light_drive_oe(light_drive_oe),
    .power_down_bit(power_down_bit));

  // ----------------------------------------------------------------
  // clock, wire monitor, timeout
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    sclk_q <= ssp_link_if_i.sclk;
    if (ssp_link_if_i.sclk && !sclk_q) begin
      mon_sh <= {mon_sh[14:0], ssp_link_if_i.sdio};
    end
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      failures++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // for a read, d is the byte the device should send back
  task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] d);
    logic [31:0] r;
    apb(1'b1, `SSP_A_CTRL, {16'h0, wr, a, d}, r);
    r = 32'h1;
    while (r[`SSP_ST_BUSY_BIT] !== 1'b0) apb(1'b0, `SSP_A_STAT, 32'h0, r);
    chk("link bits", {16'h0, wr, a, d}, {16'h0, mon_sh});
    if (!wr) begin
      apb(1'b0, `SSP_A_RDATA, 32'h0, r);
      chk("read byte", {24'h0, d}, r);
    end
  endtask

  task automatic count_light(output int n);
    n = 0;
    repeat (256) begin
      @(posedge pclk);
      if (light_drive_out === 1'b1) n++;
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    int n;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    motion_detected = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("config reset", 32'h0, {23'h0, power_down_bit, cfg_value});
    apb(1'b0, `SSP_A_STAT, 32'h0, r);
    chk("status reset", 32'h0, r);
    apb(1'b0, 8'h0c, 32'h0, r);
    chk("unmapped apb", 32'h1, {r[30:0], last_err});
    xfer(1'b0, `SSP_STAT_ADDR, {`SSP_STAT_ID, 1'b1});
    xfer(1'b1, `SSP_CFG_ADDR, 8'h15);
    chk("config write", 32'h15, {23'h0, power_down_bit, cfg_value});
    xfer(1'b0, `SSP_CFG_ADDR, 8'h15);
    xfer(1'b1, 7'h77, 8'h00);
    chk("unmapped write", 32'h15, {24'h0, cfg_value});
    chk("released after write", 32'h0, {31'h0, ssp_link_if_i.dev_sdio_oe});
    xfer(1'b0, 7'h77, 8'h00);
    xfer(1'b1, `SSP_CFG_ADDR, 8'h55);
    chk("enter power-down", 32'h155, {23'h0, power_down_bit, cfg_value});
    chk("pins released", 32'h0, {30'h0, light_drive_oe, ssp_link_if_i.dev_sdio_oe});
    apb(1'b0, `SSP_A_STAT, 32'h0, r);
    chk("host power-down view", 32'h6, r);
    // done is sticky until software writes a one to it
    apb(1'b1, `SSP_A_STAT, 32'h2, r);
    apb(1'b0, `SSP_A_STAT, 32'h0, r);
    chk("done cleared", 32'h4, r);
    apb(1'b0, `SSP_A_CTRL, 32'h0, r);
    chk("command echo", 32'hc055, r);
    xfer(1'b1, `SSP_CFG_ADDR, 8'h4a);
    chk("config kept", 32'h155, {23'h0, power_down_bit, cfg_value});
    // nobody drives the line in power-down, so the pull-up reads back
    xfer(1'b0, `SSP_CFG_ADDR, 8'hff);
    xfer(1'b1, `SSP_CFG_ADDR, 8'h0a);
    chk("leave power-down", 32'h15, {23'h0, power_down_bit, cfg_value});
    xfer(1'b0, `SSP_STAT_ADDR, {`SSP_STAT_ID, 1'b1});
    xfer(1'b0, `SSP_CFG_ADDR, 8'h15);
    motion_detected <= 1'b1;
    repeat (8) @(posedge pclk);
    count_light(n);
    chk("light on motion", 32'h100, 32'(n));
    motion_detected <= 1'b0;
    repeat (8) @(posedge pclk);
    count_light(n);
    chk("light idle", {24'h0, `SSP_LED_ON_CYC}, 32'(n));
    give_verdict();
  end
endmodule // sensor_serial_port_power_down_test

`default_nettype wire
